// >>> verilog/afs_spi_regif.sv
// serial register interface with lock key and checksums
`timescale 1ns/1ps
`include "afs_defines.svh"

module afs_spi_regif (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_conv_ready,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_dr_n,
    output afs_pkg::afs_stat_t o_status_comm
);
    import afs_pkg::*;

    // ======================================================
    // helper functions
    function automatic logic [15:0] crc_bit(input logic [15:0] c,
                                            input logic b);
        crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `AFS_CRC_POLY
                                                 : 16'h0000);
    endfunction

    function automatic logic [15:0] crc_word(input logic [15:0] c,
                                             input logic [23:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 23; i >= 0; i--) begin
            r = crc_bit(r, w[i]);
        end
        crc_word = r;
    endfunction

    function automatic logic [4:0] set_first(input logic [4:0] a,
                                             input logic [1:0] m);
        case (m)
            2'h0: set_first = a;
            2'h1: set_first = a & ~`AFS_GRP_MASK;
            2'h2: set_first = (a < `AFS_TYPE_SPLIT) ? 5'h00
                                                    : `AFS_TYPE_SPLIT;
            default: set_first = 5'h00;
        endcase
    endfunction

    function automatic logic [4:0] set_last(input logic [4:0] a,
                                            input logic [1:0] m);
        case (m)
            2'h0: set_last = a;
            2'h1: set_last = a | `AFS_GRP_MASK;
            2'h2: set_last = (a < `AFS_TYPE_SPLIT) ? `AFS_TYPE_LAST_LO
                                                   : `AFS_MAP_LAST;
            default: set_last = `AFS_MAP_LAST;
        endcase
    endfunction

    function automatic logic [4:0] step_addr(input logic [4:0] a,
                                             input logic [1:0] m);
        step_addr = (a == set_last(a, m)) ? set_first(a, m)
                                          : a + 5'h01;
    endfunction

    function automatic logic [5:0] word_len(input logic [1:0] w);
        case (w)
            2'h0: word_len = `AFS_WLEN_16;
            2'h1: word_len = `AFS_WLEN_24;
            default: word_len = `AFS_WLEN_32;
        endcase
    endfunction

    function automatic logic may_write(input logic [4:0] a,
                                       input logic unl);
        may_write = (a == `AFS_REG_LOCK) ||
                    (unl && (a >= `AFS_REG_FIRST_WR));
    endfunction

    // ======================================================
    // serial clock domain declarations
    logic sck_rst;
    afs_state_t state;
    afs_state_t next_state;
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [4:0] addr;
    logic [4:0] next_addr;
    logic [31:0] sin;
    logic [31:0] sin_nx;
    logic [31:0] sout;
    logic [15:0] crc;
    logic unl_s1;
    logic unl_s2;
    afs_stat_t cfg_s1;
    afs_stat_t cfg_s2;
    logic rd_tgl;
    logic [4:0] rd_addr_h;
    logic wr_tgl;
    afs_wr_t wr_h;

    // ======================================================
    // register clock domain declarations
    logic [23:0] regs [32];
    logic [23:0] hold;
    logic [15:0] crc_val;
    logic [15:0] crc_acc;
    logic [4:0] scan_idx;
    logic crc_valid;
    logic alert;
    logic unlocked;
    logic rq_s1;
    logic rq_s2;
    logic rq_s3;
    logic wq_s1;
    logic wq_s2;
    logic wq_s3;

    // ======================================================
    // serial side decoding
    wire [5:0] wlen = word_len(cfg_s2.width);
    wire word_done = (cnt == wlen - 6'h01);
    wire [4:0] rd_nxt = step_addr(addr, cfg_s2.read_loop);
    wire seq_end = (rd_nxt == set_first(addr, cfg_s2.read_loop));
    wire [1:0] wr_mode = cfg_s2.write_loop ? 2'h2 : 2'h0;
    wire [4:0] wr_nxt = step_addr(addr, wr_mode);
    wire wr_ok = may_write(addr, unl_s2);
    wire cmd_done = (state == AFS_ST_CMD) && (cnt == `AFS_CMD_LAST);
    wire dev_hit = (sin_nx[7:6] == `AFS_DEV_ADDR);
    wire rd_fire = ((state == AFS_ST_CMD) && (cnt == `AFS_REQ_BIT)) ||
                   ((state == AFS_ST_RD) && (cnt == 6'h00));
    wire [4:0] rd_req = (state == AFS_ST_CMD) ? sin_nx[4:0] : rd_nxt;
    wire wr_fire = (state == AFS_ST_WR) && word_done && wr_ok;
    wire [23:0] wr_word = (cfg_s2.width == 2'h0) ?
                          {sin_nx[15:0], 8'h00} :
                          (cfg_s2.width == 2'h1) ? sin_nx[23:0]
                                                 : sin_nx[31:8];
    wire [31:0] ld_word = (cfg_s2.width == 2'h0) ? {hold[23:8], 16'h0000}
                                                 : {hold, 8'h00};

    assign sck_rst = ~i_rstn | i_cs_n;
    assign sin_nx = {sin[30:0], i_sdi};

    always_comb begin
        next_state = state;
        next_cnt = cnt + 6'h01;
        next_addr = addr;
        case (state)
            AFS_ST_CMD: begin
                if (cmd_done) begin
                    next_cnt = 6'h00;
                    next_addr = sin_nx[5:1];
                    if (!dev_hit) begin
                        next_state = AFS_ST_SKIP;
                    end else if (sin_nx[0]) begin
                        next_state = AFS_ST_RD;
                    end else begin
                        next_state = AFS_ST_WR;
                    end
                end
            end
            AFS_ST_RD: begin
                if (word_done) begin
                    next_cnt = 6'h00;
                    next_addr = rd_nxt;
                    if (seq_end && cfg_s2.rcrc_en) begin
                        next_state = AFS_ST_CRC;
                    end
                end
            end
            AFS_ST_CRC: begin
                if (cnt == `AFS_CRC_LAST) begin
                    next_cnt = 6'h00;
                    next_state = AFS_ST_RD;
                end
            end
            AFS_ST_WR: begin
                if (word_done) begin
                    next_cnt = 6'h00;
                    if (wr_ok) begin
                        next_addr = wr_nxt;
                    end
                end
            end
            AFS_ST_SKIP: begin
                next_cnt = cnt;
            end
            default: begin
                next_state = AFS_ST_CMD;
            end
        endcase
    end

    // ======================================================
    // serial side, rising edge: sampling and sequencing
    always_ff @(posedge i_sck or posedge sck_rst) begin
        if (sck_rst) begin
            state <= AFS_ST_CMD;
            cnt <= 6'h00;
            addr <= 5'h00;
            sin <= 32'h00000000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            sin <= sin_nx;
        end
    end

    // handoff registers survive chip select so no event is lost
    always_ff @(posedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_tgl <= 1'b0;
            rd_addr_h <= 5'h00;
            wr_tgl <= 1'b0;
            wr_h <= '0;
            unl_s1 <= 1'b0;
            unl_s2 <= 1'b0;
            cfg_s1 <= afs_stat_t'(`AFS_STAT_RST);
            cfg_s2 <= afs_stat_t'(`AFS_STAT_RST);
        end else begin
            unl_s1 <= unlocked;
            unl_s2 <= unl_s1;
            cfg_s1 <= afs_stat_t'(regs[`AFS_REG_STAT]);
            cfg_s2 <= cfg_s1;
            if (rd_fire) begin
                rd_tgl <= ~rd_tgl;
                rd_addr_h <= rd_req;
            end
            if (wr_fire) begin
                wr_tgl <= ~wr_tgl;
                wr_h <= '{addr: addr, data: wr_word};
            end
        end
    end

    // ======================================================
    // serial side, falling edge: output shifting
    always_ff @(negedge i_sck or posedge sck_rst) begin
        if (sck_rst) begin
            o_sdo <= 1'b0;
            o_sdo_oe <= 1'b0;
            sout <= 32'h00000000;
            crc <= `AFS_CRC_INIT;
        end else begin
            case (state)
                AFS_ST_RD: begin
                    o_sdo_oe <= 1'b1;
                    if (cnt == 6'h00) begin
                        o_sdo <= ld_word[31];
                        sout <= {ld_word[30:0], 1'b0};
                        crc <= crc_bit(crc, ld_word[31]);
                    end else begin
                        o_sdo <= sout[31];
                        sout <= {sout[30:0], 1'b0};
                        crc <= crc_bit(crc, sout[31]);
                    end
                end
                AFS_ST_CRC: begin
                    o_sdo_oe <= 1'b1;
                    if (cnt == 6'h00) begin
                        o_sdo <= crc[15];
                        sout <= {crc[14:0], 17'h00000};
                        crc <= `AFS_CRC_INIT;
                    end else begin
                        o_sdo <= sout[31];
                        sout <= {sout[30:0], 1'b0};
                    end
                end
                default: begin
                    o_sdo_oe <= 1'b0;
                end
            endcase
        end
    end

    // ======================================================
    // register side: crossing of requests
    wire rd_ev = rq_s2 ^ rq_s3;
    wire wr_ev = wq_s2 ^ wq_s3;
    wire wr_go = wr_ev && may_write(wr_h.addr, unlocked);
    wire [23:0] rd_mux = (rd_addr_h == `AFS_REG_LOCK) ?
                         {regs[`AFS_REG_LOCK][23:16], crc_val}
                         : regs[rd_addr_h];
    wire [15:0] crc_new = crc_word(crc_acc, regs[scan_idx]);
    wire scan_end = (scan_idx == `AFS_SCAN_LAST);
    wire alert_en = regs[`AFS_REG_STAT][17];

    assign o_status_comm = afs_stat_t'(regs[`AFS_REG_STAT]);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rq_s1 <= 1'b0;
            rq_s2 <= 1'b0;
            rq_s3 <= 1'b0;
            wq_s1 <= 1'b0;
            wq_s2 <= 1'b0;
            wq_s3 <= 1'b0;
            hold <= `AFS_REG_RST;
            unlocked <= 1'b1;
        end else begin
            rq_s1 <= rd_tgl;
            rq_s2 <= rq_s1;
            rq_s3 <= rq_s2;
            wq_s1 <= wr_tgl;
            wq_s2 <= wq_s1;
            wq_s3 <= wq_s2;
            unlocked <= (regs[`AFS_REG_LOCK][23:16] == `AFS_LOCK_KEY);
            if (rd_ev) begin
                hold <= rd_mux;
            end
        end
    end

    // ======================================================
    // register map
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < 32; i++) begin
                regs[i] <= `AFS_REG_RST;
            end
            regs[`AFS_REG_STAT] <= `AFS_STAT_RST;
            regs[`AFS_REG_LOCK] <= {`AFS_LOCK_RST, 16'h0000};
        end else if (wr_go) begin
            if (wr_h.addr == `AFS_REG_LOCK) begin
                regs[`AFS_REG_LOCK] <= {wr_h.data[23:16], 16'h0000};
            end else begin
                regs[wr_h.addr] <= wr_h.data;
            end
        end
    end

    // ======================================================
    // background configuration checksum and alert
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scan_idx <= `AFS_SCAN_FIRST;
            crc_acc <= `AFS_CRC_INIT;
            crc_val <= `AFS_CRC_INIT;
            crc_valid <= 1'b0;
        end else if (scan_end) begin
            scan_idx <= `AFS_SCAN_FIRST;
            crc_acc <= `AFS_CRC_INIT;
            crc_val <= crc_new;
            crc_valid <= 1'b1;
        end else begin
            scan_idx <= scan_idx + 5'h01;
            crc_acc <= crc_new;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            alert <= 1'b0;
            o_dr_n <= 1'b1;
        end else begin
            if (scan_end && crc_valid && (crc_new != crc_val) &&
                alert_en) begin
                alert <= 1'b1;
            end else if (!alert_en) begin
                alert <= 1'b0;
            end
            o_dr_n <= ~(i_conv_ready | alert);
        end
    end

endmodule

// >>> verilog/afs_defines.svh
// constants of the converter front end serial register interface
`ifndef AFS_DEFINES_SVH
`define AFS_DEFINES_SVH

// ==========================================================
// control byte and addressing
`define AFS_DEV_ADDR 2'h1
`define AFS_CMD_LAST 6'h07
`define AFS_REQ_BIT 6'h06
`define AFS_REG_FIRST_WR 5'h08
`define AFS_REG_MOD 5'h08
`define AFS_REG_STAT 5'h0A
`define AFS_REG_LOCK 5'h1F
`define AFS_TYPE_SPLIT 5'h08
`define AFS_TYPE_LAST_LO 5'h07
`define AFS_MAP_LAST 5'h1F
`define AFS_GRP_MASK 5'h03

// ==========================================================
// reset values and lock key
`define AFS_STAT_RST 24'hA80000
`define AFS_LOCK_KEY 8'hA5
`define AFS_LOCK_RST 8'hA5
`define AFS_REG_RST 24'h000000

// ==========================================================
// word lengths in serial clock cycles
`define AFS_WLEN_16 6'h10
`define AFS_WLEN_24 6'h18
`define AFS_WLEN_32 6'h20
`define AFS_CRC_LAST 6'h0F

// ==========================================================
// checksum engine
`define AFS_CRC_POLY 16'h8005
`define AFS_CRC_INIT 16'h0000
`define AFS_SCAN_FIRST 5'h09
`define AFS_SCAN_LAST 5'h1E

`endif

// >>> verilog/afs_pkg.sv
// types shared by the serial register interface
package afs_pkg;

    // ======================================================
    // serial interface states
    typedef enum logic [2:0] {
        AFS_ST_CMD = 3'b000,
        AFS_ST_RD = 3'b001,
        AFS_ST_WR = 3'b010,
        AFS_ST_CRC = 3'b011,
        AFS_ST_SKIP = 3'b100
    } afs_state_t;

    // ======================================================
    // status and communication register layout
    typedef struct packed {
        logic [1:0] read_loop;
        logic write_loop;
        logic [1:0] width;
        logic rcrc_en;
        logic alert_en;
        logic [16:0] spare;
    } afs_stat_t;

    // ======================================================
    // write handed from the serial side to the register side
    typedef struct packed {
        logic [4:0] addr;
        logic [23:0] data;
    } afs_wr_t;

endpackage

// >>> verif/afs_spi_regif_chk.sv
// assertions on the serial register interface ports
`timescale 1ns/1ps
`include "afs_defines.svh"
module afs_spi_regif_chk (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_conv_ready,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic o_dr_n,
    input wire afs_pkg::afs_stat_t o_status_comm
);
    import afs_pkg::*;
    // ======================================================
    // rising clock edges since select fell, control byte
    logic [5:0] nrise;
    logic [7:0] ctl;
    logic ctl_done;
    logic ctl_ours;
    assign ctl_done = nrise >= 6'h08;
    assign ctl_ours = ctl[7:6] == `AFS_DEV_ADDR;
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            nrise <= 6'h00;
            ctl <= 8'h00;
        end else begin
            nrise <= (nrise == 6'h3F) ? nrise : nrise + 6'h01;
            ctl <= ctl_done ? ctl : {ctl[6:0], i_sdi};
        end
    end
    // ======================================================
    // assertions
    AST_DESELECT_QUIET:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_cs_n |-> !o_sdo_oe) else $error("output driven while deselected");
    AST_CTRL_QUIET:
    assert property (@(posedge i_sck) disable iff (i_cs_n || !i_rstn)
        !ctl_done |-> !o_sdo_oe) else $error("output driven in control byte");
    AST_FOREIGN_ADDR:
    assert property (@(posedge i_sck) disable iff (i_cs_n || !i_rstn)
        (ctl_done && !ctl_ours) |-> !o_sdo_oe)
        else $error("answered a foreign device address");
    AST_WRITE_QUIET:
    assert property (@(posedge i_sck) disable iff (i_cs_n || !i_rstn)
        (ctl_done && !ctl[0]) |-> !o_sdo_oe) else $error("output in write");
    AST_READ_DRIVES:
    assert property (@(posedge i_sck) disable iff (i_cs_n || !i_rstn)
        (ctl_done && ctl[0] && ctl_ours) |-> o_sdo_oe)
        else $error("read data not driven");
    AST_SHIFT_ON_FALL:
    assert property (@(posedge i_clk) disable iff (!i_rstn || i_cs_n)
        (i_sck && !$past(i_cs_n)) |-> $stable(o_sdo))
        else $error("output moved while clock high");
    AST_RESET_DEFAULTS:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(i_rstn) |-> (o_status_comm == `AFS_STAT_RST) && o_dr_n)
        else $error("wrong value after reset");
    AST_READY_PULLS_LOW:
    assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_conv_ready |-> ##[1:2] !o_dr_n) else $error("ready pin not low");
    // ======================================================
    // covers
    COV_READ: cover property (@(posedge i_sck) ctl_done && ctl[0] && o_sdo_oe);
    COV_WRITE: cover property (@(posedge i_sck) ctl_done && !ctl[0]);
    COV_ALERT: cover property (@(posedge i_clk)
        o_status_comm.alert_en && !o_dr_n);
endmodule

bind afs_spi_regif afs_spi_regif_chk afs_spi_regif_chk_inst (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_sdi(i_sdi),
    .i_conv_ready(i_conv_ready),
    .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe),
    .o_dr_n(o_dr_n),
    .o_status_comm(o_status_comm)
);

// >>> verif/afs_host_model.sv
// host side serial master model
`timescale 1ns/1ps
module afs_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_sdo_oe
);
    logic [127:0] rx;
    logic last;
    event done;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
        last = 1'b0;
    end
    // ======================================================
    // one frame, msb first, gapless; undriven line reads inverted
    task automatic frame(input bit mode, input int n, input logic [127:0] tx);
        rx = 128'h0;
        o_sck = mode;
        #13;
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_sck = 1'b0;
            o_sdi = tx[i];
            #32;
            o_sck = 1'b1;
            rx = {rx[126:0], i_sdo_oe ? i_sdo : ~last};
            last = i_sdo_oe ? i_sdo : last;
            #32;
        end
        o_sck = mode;
        #20;
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi;
        ->done;
        #100;
    endtask
endmodule

// >>> verif/testbench.sv
// self-checking bench for the serial register interface
`timescale 1ns/1ps
`include "afs_defines.svh"
module testbench;
    import afs_pkg::*;
    typedef struct packed {
        logic [127:0] val;
        logic [127:0] msk;
    } afs_exp_t;
    localparam logic [1:0] DV = `AFS_DEV_ADDR;
    logic i_clk, i_rstn, i_conv_ready, sck, cs_n, sdi, sdo, sdo_oe, dr_n;
    afs_stat_t stat;
    afs_exp_t exp_q[$];
    afs_exp_t e;
    int bad_count, n_checks, cyc, seed, k, w;
    logic [23:0] d [0:31];
    logic [23:0] v;
    logic [4:0] sa [4] = '{5'h0D, 5'h0F, 5'h07, 5'h07};
    logic [4:0] sb [4] = '{5'h0D, 5'h0C, 5'h00, 5'h08};

    afs_spi_regif afs_spi_regif_inst (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi), .i_conv_ready(i_conv_ready),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_dr_n(dr_n), .o_status_comm(stat));
    afs_host_model afs_host_model_inst (.o_sck(sck), .o_cs_n(cs_n),
        .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));

    always #5 i_clk = ~i_clk;
    // ======================================================
    // shared tasks
    task automatic check(input logic [127:0] got, input logic [127:0] want);
        n_checks++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, got, want);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] fmt(input logic [23:0] x);
        return w == 32 ? {x, 8'h00} : 32'(x >> (24 - w));
    endfunction
    function automatic logic [15:0] crc(input logic [15:0] c0,
            input logic [23:0] x);
        logic [15:0] c;
        c = c0;
        for (int i = 23; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction
    // background checksum over the modelled configuration registers
    function automatic logic [15:0] mapcrc();
        logic [15:0] c;
        c = 16'h0000;
        for (int i = `AFS_SCAN_FIRST; i <= `AFS_SCAN_LAST; i++) begin
            c = crc(c, d[i]);
        end
        return c;
    endfunction
    task automatic xfer(input logic [6:0] a, input bit r, input int n,
            input logic [119:0] tx, input logic [127:0] ev,
            input logic [127:0] em);
        exp_q.push_back('{ev, em});
        afs_host_model_inst.frame(1'($random(seed)), 8 + n,
            ({120'h0, a, r} << n) | 128'(tx));
    endtask
    task automatic wrw(input logic [4:0] a, input logic [23:0] x);
        xfer({DV, a}, 1'b0, w, 120'(fmt(x)), 128'h0, 128'h0);
    endtask
    task automatic rd2(input logic [4:0] a, input logic [23:0] x0, x1);
        xfer({DV, a}, 1'b1, 2 * w, 120'h0,
            (128'(fmt(x0)) << w) | 128'(fmt(x1)), (128'h1 << (2 * w)) - 1);
    endtask
    task automatic wst(input logic [23:0] s);
        wrw(`AFS_REG_STAT, s);
        d[`AFS_REG_STAT] = s;
        w = (s[20:19] == 2'b00) ? 16 : (s[20] ? 32 : 24);
        repeat (10) @(negedge i_clk);
        check(stat, s);
    endtask
    // ======================================================
    // monitor: each finished frame against the oldest note
    always @(afs_host_model_inst.done) begin
        e = exp_q.pop_front();
        if (e.msk !== 128'h0) begin
            check(afs_host_model_inst.rx & e.msk, e.val & e.msk);
        end
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            $display("[ERR] %0t run took too long", $time);
            final_report();
        end
    end
    // ======================================================
    // main sequence
    initial begin
        seed = 32'h81c3;
        i_clk = 1'b0;
        i_rstn = 1'b0;
        i_conv_ready = 1'b0;
        w = 24;
        for (k = 0; k < 32; k++) d[k] = 24'h0;
        repeat (6) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clk);
        check(stat, `AFS_STAT_RST);
        rd2(5'h0A, `AFS_STAT_RST, 24'h0);
        for (k = 8; k < 16; k++) d[k] = 24'($random(seed));
        d[9] = 24'h0;
        d[10] = `AFS_STAT_RST;
        d[11] = 24'h0;
        xfer({DV, 5'h0C}, 1'b0, 96, {d[12], d[13], d[14], d[15]},
            0, 0);
        wrw(5'h08, d[8]);
        $display("reset and write test done");
        for (k = 0; k < 4; k++) begin
            wst({2'(k), 1'b1, 2'b01, 2'b00, 17'h0});
            rd2(sa[k], d[sa[k]], d[sb[k]]);
        end
        $display("read loop test done");
        wst({2'b00, 1'b0, 2'b01, 2'b00, 17'h0});
        v = 24'($random(seed));
        d[13] = 24'($random(seed));
        xfer({DV, 5'h0D}, 1'b0, 48, {v, d[13]}, 0, 0);
        xfer({DV, 5'h03}, 1'b0, 48, {v, v}, 0, 0);
        xfer({2'b00, 5'h0D}, 1'b0, 24, v, 0, 0);
        xfer({2'b10, 5'h0D}, 1'b1, 24, 0, 0, 0);
        xfer({DV, 5'h0D}, 1'b0, 12, v[23:12], 0, 0);
        rd2(5'h0D, d[13], d[13]);
        rd2(5'h03, 24'h0, 24'h0);
        $display("refusal test done");
        wrw(`AFS_REG_LOCK, 24'h000000);
        wrw(5'h0D, v);
        rd2(5'h0D, d[13], d[13]);
        xfer({DV, 5'h1F}, 1'b1, 24, 0, 0, 128'hFF0000);
        wrw(`AFS_REG_LOCK, {`AFS_LOCK_KEY, 16'h0});
        wrw(5'h0D, v);
        d[13] = v;
        rd2(5'h0D, d[13], d[13]);
        $display("lock test done");
        for (k = 0; k < 2; k++) begin
            wst({2'b00, 1'b0, k ? 2'b10 : 2'b00, 2'b00, 17'h0});
            d[14] = 24'($random(seed)) & (k ? 24'hFFFFFF : 24'hFFFF00);
            wrw(5'h0E, d[14]);
            rd2(5'h0E, d[14], d[14]);
        end
        wst({2'b00, 1'b0, 2'b01, 2'b10, 17'h0});
        xfer({DV, 5'h0D}, 1'b1, 40, 0, {d[13], crc(16'h0000, d[13])},
            (128'h1 << 40) - 1);
        $display("format and read checksum test done");
        wst({2'b00, 1'b0, 2'b01, 2'b00, 17'h0});
        check(dr_n, 1'b1);
        @(negedge i_clk) i_conv_ready = 1'b1;
        @(negedge i_clk) check(dr_n, 1'b0);
        i_conv_ready = 1'b0;
        @(negedge i_clk) check(dr_n, 1'b1);
        xfer({DV, 5'h1F}, 1'b1, 24, 0, {`AFS_LOCK_KEY, mapcrc()},
            128'hFFFFFF);
        wst({2'b00, 1'b0, 2'b01, 2'b01, 17'h0});
        wrw(5'h0D, ~v);
        for (k = 0; k < 200 && dr_n !== 1'b0; k++) @(negedge i_clk);
        check(dr_n, 1'b0);
        $display("ready pin test done");
        i_rstn = 1'b0;
        repeat (3) @(negedge i_clk);
        check({stat, dr_n}, {`AFS_STAT_RST, 1'b1});
        i_rstn = 1'b1;
        w = 24;
        repeat (4) @(negedge i_clk);
        rd2(5'h0D, 24'h0, 24'h0);
        $display("second reset test done");
        final_report();
    end
endmodule
